// ===== rtl/motion_cmd_trigger_unit.sv
// Purpose: Host command channel, result queue, breakpoints, trigger and limit enables
// Assumes: APB slave, zero wait states, one board clock
// Notes:   Function semantics beyond the decoded ids are left to the core outside
`timescale 1ns/1ns
module motion_cmd_trigger_unit (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             cmd_valid,
	output logic [7:0]       cmd_axis,
	output logic [7:0]       cmd_fid,
	output logic [31:0]      cmd_data,
	output logic [1:0]       cmd_wcount,
	input  wire logic        res_valid,
	input  wire logic [7:0]  res_axis,
	input  wire logic [7:0]  res_fid,
	input  wire logic [31:0] res_data,
	input  wire logic [127:0] axis_pos,
	input  wire logic [3:0]  axis_start,
	input  wire logic [7:0]  io_in,
	input  wire logic [7:0]  io_dir_in,
	output logic      [7:0]  io_in_value,
	output logic      [7:0]  brk_out,
	output logic      [3:0]  time_brk_arm,
	output logic      [3:0]  trig_start,
	input  wire logic [11:0] limit_in,
	output logic      [3:0]  axis_halt
);

	localparam int QW = motion_cmd_pkg::QPTR_W;
	localparam int NA = motion_cmd_pkg::NUM_AXES;

	typedef struct packed {
		logic [7:0]  w_axis;
		logic [7:0]  w_fid;
		logic [1:0]  w_mode;
		logic [7:0]  w_wcnt;
		logic [31:0] w_data;
		motion_cmd_pkg::ret_entry_t last;
		logic        last_valid;
		logic        ferr;
		logic        pend_read;
		logic [QW:0] count;
		logic [QW-1:0] rd_ptr;
		logic [QW-1:0] wr_ptr;
		logic        cmd_valid;
		logic [7:0]  cmd_axis;
		logic [7:0]  cmd_fid;
		logic [31:0] cmd_data;
		logic [1:0]  cmd_wcount;
		logic [15:0] trig_en;
		logic [15:0] limit_en;
		logic [15:0] cfg;
		logic [3:0]  time_arm;
		logic [NA-1:0][31:0] base;
		logic [NA-1:0][31:0] brk_pos;
		logic [NA-1:0]       brk_armed;
		logic [NA-1:0]       brk_rel;
		logic [NA-1:0][2:0]  brk_link;
		logic [NA-1:0]       brk_hit;
		logic [3:0]  trig_start;
		logic [3:0]  halt;
		logic [3:0]  trig_prev;
		logic [11:0] lim_prev;
	} state_t;

	state_t                         s_reg;
	state_t                         s_next;
	motion_cmd_pkg::ret_entry_t     queue_mem [motion_cmd_pkg::QUEUE_DEPTH];
	logic [31:0]                    rd_word;
	logic [7:0]                     io_s1_reg;
	logic [7:0]                     io_s2_reg;
	logic [7:0]                     io_s3_reg;
	logic [7:0]                     io_clean_reg;
	logic [11:0]                    lim_s1_reg;
	logic [11:0]                    lim_s2_reg;
	logic [11:0]                    lim_s3_reg;
	logic [11:0]                    lim_clean_reg;
	logic                           wr_access;
	logic                           rd_access;
	logic                           q_push;
	logic [3:0]                     brk_line;

	// Zero-wait slave: every access completes in its first access cycle
	assign pready    = 1'b1;
	assign pslverr   = 1'b0;
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && penable && !pwrite;

	// Pin inputs pass three stages; a value counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			io_s1_reg     <= 8'h00;
			io_s2_reg     <= 8'h00;
			io_s3_reg     <= 8'h00;
			io_clean_reg  <= 8'h00;
			lim_s1_reg    <= 12'h000;
			lim_s2_reg    <= 12'h000;
			lim_s3_reg    <= 12'h000;
			lim_clean_reg <= 12'h000;
		end
		else
		begin
			io_s1_reg  <= io_in;
			io_s2_reg  <= io_s1_reg;
			io_s3_reg  <= io_s2_reg;
			lim_s1_reg <= limit_in;
			lim_s2_reg <= lim_s1_reg;
			lim_s3_reg <= lim_s2_reg;
			for (int i = 0; i < 8; i++)
				if (io_s2_reg[i] == io_s3_reg[i])
					io_clean_reg[i] <= io_s3_reg[i];
			for (int i = 0; i < 12; i++)
				if (lim_s2_reg[i] == lim_s3_reg[i])
					lim_clean_reg[i] <= lim_s3_reg[i];
		end
	end

	// Result queue storage; results are kept in arrival order
	assign q_push = res_valid && !s_reg.pend_read &&
		(s_reg.count != 5'(motion_cmd_pkg::QUEUE_DEPTH));
	always_ff @(posedge pclk)
	begin
		if (q_push)
			queue_mem[s_reg.wr_ptr] <= '{res_axis, res_fid, res_data};
	end

	// Register read mux
	always_comb
	begin
		rd_word = 32'h0000_0000;
		unique case (paddr)
			motion_cmd_pkg::OFS_CMD_WORD0: rd_word = {s_reg.w_wcnt, 6'h00, s_reg.w_mode,
				s_reg.w_fid, s_reg.w_axis};
			motion_cmd_pkg::OFS_CMD_DATA:  rd_word = s_reg.w_data;
			motion_cmd_pkg::OFS_RET_HEAD:  rd_word = {16'h0000, s_reg.last.fid, s_reg.last.axis};
			motion_cmd_pkg::OFS_RET_DATA:  rd_word = s_reg.last.data;
			motion_cmd_pkg::OFS_STATUS:    rd_word = {20'h00000, s_reg.ferr, s_reg.last_valid,
				(s_reg.count == 5'(motion_cmd_pkg::QUEUE_DEPTH)), (s_reg.count == 5'h00),
				3'h0, s_reg.count};
			motion_cmd_pkg::OFS_TRIG_EN:   rd_word = {16'h0000, s_reg.trig_en};
			motion_cmd_pkg::OFS_LIMIT_EN:  rd_word = {16'h0000, s_reg.limit_en};
			motion_cmd_pkg::OFS_BRK_CFG:   rd_word = {16'h0000, s_reg.cfg};
			default:
			begin
				for (int a = 0; a < NA; a++)
					if (paddr == 8'(motion_cmd_pkg::OFS_BRK_POS0 + 4 * a))
						rd_word = s_reg.brk_pos[a];
			end
		endcase
	end

	// Breakpoint hit flags, bit n for axis n; board type places them on brk_out below
	always_comb
	begin
		brk_line = 4'h0;
		for (int a = 0; a < NA; a++)
			brk_line[a] = s_reg.brk_hit[a];
	end

	// Next-state logic for the whole block
	always_comb
	begin
		logic [7:0]  fid;
		logic [15:0] arg;
		logic [31:0] goal;
		logic        popped;
		s_next = s_reg;
		fid    = s_reg.w_fid;
		arg    = s_reg.w_data[15:0];
		goal   = 32'h0000_0000;
		popped = 1'b0;
		s_next.cmd_valid  = 1'b0;
		s_next.trig_start = 4'h0;
		s_next.time_arm   = 4'h0;

		// Result arrival: answer a pending send-and-read, else enqueue unless the queue is full
		if (res_valid && s_reg.pend_read)
		begin
			s_next.last       = '{res_axis, res_fid, res_data};
			s_next.last_valid = 1'b1;
			s_next.pend_read  = 1'b0;
		end

		// Software register writes
		if (wr_access)
		begin
			unique case (paddr)
				motion_cmd_pkg::OFS_CMD_WORD0:
				begin
					s_next.w_axis = pwdata[motion_cmd_pkg::CMD_AXIS_LSB +: 8];
					s_next.w_fid  = pwdata[motion_cmd_pkg::CMD_FID_LSB +: 8];
					s_next.w_mode = pwdata[motion_cmd_pkg::CMD_MODE_LSB +: 2];
					s_next.w_wcnt = pwdata[motion_cmd_pkg::CMD_WCNT_LSB +: 8];
				end
				motion_cmd_pkg::OFS_CMD_DATA: s_next.w_data = pwdata;
				motion_cmd_pkg::OFS_CMD_GO:
				begin
					if (s_reg.w_mode == motion_cmd_pkg::OP_READ)
					begin
						// Word count is ignored for a pure read
						if (s_reg.count != 5'h00)
						begin
							s_next.last       = queue_mem[s_reg.rd_ptr];
							s_next.last_valid = 1'b1;
							popped            = 1'b1;
						end
						else
							s_next.last_valid = res_valid && s_reg.pend_read; // Arrival wins
					end
					else if (s_reg.w_mode == motion_cmd_pkg::OP_SEND ||
						s_reg.w_mode == motion_cmd_pkg::OP_SEND_READ)
					begin
						s_next.cmd_valid  = 1'b1;
						s_next.cmd_axis   = s_reg.w_axis;
						s_next.cmd_fid    = fid;
						s_next.cmd_data   = s_reg.w_data;
						// Host gives 2 + words; more than two data words is clipped
						s_next.cmd_wcount = (s_reg.w_wcnt > 8'h04) ? 2'h2 :
							(s_reg.w_wcnt < 8'h02) ? 2'h0 : 2'(s_reg.w_wcnt - 8'h02);
						// Send-only keeps the answer queued; send-and-read captures it
						s_next.pend_read  = (s_reg.w_mode == motion_cmd_pkg::OP_SEND_READ);
						s_next.last_valid = 1'b0;
						s_next.ferr       = 1'b0;
						unique case (fid)
							motion_cmd_pkg::FID_ENABLE_BRK:
							begin
								if (!s_reg.cfg[motion_cmd_pkg::CFG_SERVO_BIT] &&
									!s_reg.cfg[motion_cmd_pkg::CFG_CLOSED_BIT])
									s_next.ferr = 1'b1;
								else
									for (int a = 0; a < NA; a++)
										if (s_reg.w_axis == 8'(a))
										begin
											s_next.brk_armed[a] = 1'b1;
											s_next.brk_hit[a]   = 1'b0;
											s_next.brk_rel[a]   = (arg == motion_cmd_pkg::BRK_MODE_REL);
											s_next.base[a]      = axis_pos[32*a +: 32];
											if (s_reg.cfg[motion_cmd_pkg::CFG_SERVO_BIT])
												s_next.time_arm[a] = 1'b1;
										end
							end
							motion_cmd_pkg::FID_ENABLE_TRIG:
								s_next.trig_en = arg & motion_cmd_pkg::TRIG_EN_MASK;
							motion_cmd_pkg::FID_ENABLE_LIMIT:
								s_next.limit_en = arg & motion_cmd_pkg::LIMIT_EN_MASK;
							motion_cmd_pkg::FID_LINK_TRIG:
								for (int a = 0; a < NA; a++)
									if (s_reg.w_axis == 8'(a))
										s_next.brk_link[a] = (arg > 16'h0004) ? 3'h0 : 3'(arg);
							motion_cmd_pkg::FID_FLUSH:
							begin
								s_next.count  = '0;
								s_next.rd_ptr = s_reg.wr_ptr;
							end
							default: ;
						endcase
					end
				end
				motion_cmd_pkg::OFS_BRK_CFG: s_next.cfg = pwdata[15:0];
				default:
				begin
					for (int a = 0; a < NA; a++)
						if (paddr == 8'(motion_cmd_pkg::OFS_BRK_POS0 + 4 * a))
							s_next.brk_pos[a] = pwdata;
				end
			endcase
		end

		// Queue pointers; a flush in the same cycle wins over push and pop
		if (!(wr_access && paddr == motion_cmd_pkg::OFS_CMD_GO &&
			(s_reg.w_mode == motion_cmd_pkg::OP_SEND ||
			s_reg.w_mode == motion_cmd_pkg::OP_SEND_READ) &&
			fid == motion_cmd_pkg::FID_FLUSH))
		begin
			if (q_push)
				s_next.wr_ptr = s_reg.wr_ptr + 4'h1;
			if (popped)
				s_next.rd_ptr = s_reg.rd_ptr + 4'h1;
			s_next.count = s_reg.count + 5'(q_push) - 5'(popped);
		end

		// Breakpoint comparators, one match per arming; mode never feeds the trajectory
		for (int a = 0; a < NA; a++)
		begin
			goal = s_reg.brk_rel[a] ? (s_reg.base[a] + s_reg.brk_pos[a]) : s_reg.brk_pos[a];
			if (s_reg.brk_armed[a] && axis_pos[32*a +: 32] == goal &&
				!(!s_reg.cfg[motion_cmd_pkg::CFG_SERVO_BIT] &&
				s_reg.cfg[motion_cmd_pkg::CFG_OPEN_LSB + a]))
			begin
				s_next.brk_hit[a]   = 1'b1;
				s_next.brk_armed[a] = 1'b0;
				if (s_reg.brk_link[a] != 3'h0)
					s_next.trig_start[2'(s_reg.brk_link[a] - 3'h1)] = 1'b1;
			end
		end

		// Trigger inputs: rising active edge on an enabled input bit starts its buffer
		for (int t = 0; t < 4; t++)
		begin
			if (s_reg.trig_en[t] && !io_dir_in[t] && io_clean_reg[t] && !s_reg.trig_prev[t])
				s_next.trig_start[t] = 1'b1;
		end
		s_next.trig_prev = io_clean_reg[3:0];

		// Limit and home: enabled active edge halts the axis; homes D11..D8, pairs D7..D0
		for (int a = 0; a < NA; a++)
		begin
			s_next.halt[a] = 1'b0;
			if ((s_reg.limit_en[11 - a] && lim_clean_reg[11 - a] && !s_reg.lim_prev[11 - a]) ||
				(s_reg.limit_en[7 - 2*a] && lim_clean_reg[7 - 2*a] && !s_reg.lim_prev[7 - 2*a]) ||
				(s_reg.limit_en[6 - 2*a] && lim_clean_reg[6 - 2*a] && !s_reg.lim_prev[6 - 2*a]))
				s_next.halt[a] = 1'b1;
		end
		s_next.lim_prev = lim_clean_reg;
	end

	// State register; enables start cleared after power-up
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg          <= '0;
			s_reg.trig_en  <= motion_cmd_pkg::EN_RESET;
			s_reg.limit_en <= motion_cmd_pkg::EN_RESET;
		end
		else
			s_reg <= s_next;
	end

	// Breakpoint lines sit on bit n (stepper) or bit n+4 (servo)
	always_comb
	begin
		brk_out = 8'h00;
		if (s_reg.cfg[motion_cmd_pkg::CFG_SERVO_BIT])
			brk_out[7:4] = brk_line;
		else
			brk_out[3:0] = brk_line;
	end

	assign prdata       = rd_word;
	assign io_in_value  = io_clean_reg;
	assign cmd_valid    = s_reg.cmd_valid;
	assign cmd_axis     = s_reg.cmd_axis;
	assign cmd_fid      = s_reg.cmd_fid;
	assign cmd_data     = s_reg.cmd_data;
	assign cmd_wcount   = s_reg.cmd_wcount;
	assign time_brk_arm = s_reg.time_arm;
	assign trig_start   = s_reg.trig_start;
	assign axis_halt    = s_reg.halt;

endmodule : motion_cmd_trigger_unit

// ===== rtl/motion_cmd_pkg.sv
// Purpose: Shared constants and carriers for the motion command and trigger unit
// Assumes: 32-bit APB, one clock, four axes
// Notes:   Offsets are byte addresses of aligned words
package motion_cmd_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CMD_WORD0  = 8'h00; // axis, function id, mode, word count
	localparam logic [7:0] OFS_CMD_DATA   = 8'h04; // two 16-bit data words
	localparam logic [7:0] OFS_CMD_GO     = 8'h08; // write starts the operation
	localparam logic [7:0] OFS_RET_HEAD   = 8'h0c; // axis and function id of last result
	localparam logic [7:0] OFS_RET_DATA   = 8'h10; // data of last result
	localparam logic [7:0] OFS_STATUS     = 8'h14; // queue level, flags
	localparam logic [7:0] OFS_TRIG_EN    = 8'h18; // trigger input enable word
	localparam logic [7:0] OFS_LIMIT_EN   = 8'h1c; // limit and home enable word
	localparam logic [7:0] OFS_BRK_CFG    = 8'h20; // board type and per-axis loop mode
	localparam logic [7:0] OFS_BRK_POS0   = 8'h30; // breakpoint position, axis 0; step 4

	// Field layout of OFS_CMD_WORD0
	localparam int CMD_AXIS_LSB  = 0;
	localparam int CMD_FID_LSB   = 8;
	localparam int CMD_MODE_LSB  = 16;
	localparam int CMD_WCNT_LSB  = 24;

	// Configuration field positions
	localparam int CFG_SERVO_BIT  = 0;
	localparam int CFG_CLOSED_BIT = 1;
	localparam int CFG_OPEN_LSB   = 4;
	localparam int CFG_LINK_LSB   = 8;

	// Status field positions
	localparam int ST_LEVEL_LSB  = 0;
	localparam int ST_EMPTY_BIT  = 8;
	localparam int ST_FULL_BIT   = 9;
	localparam int ST_VALID_BIT  = 10;
	localparam int ST_FERR_BIT   = 11;

	// Transfer operation codes
	localparam logic [1:0] OP_SEND      = 2'h0;
	localparam logic [1:0] OP_SEND_READ = 2'h1;
	localparam logic [1:0] OP_READ      = 2'h2;

	// Function ids decoded in this block
	localparam logic [7:0] FID_ENABLE_BRK   = 8'h10;
	localparam logic [7:0] FID_ENABLE_TRIG  = 8'h11;
	localparam logic [7:0] FID_ENABLE_LIMIT = 8'h12;
	localparam logic [7:0] FID_LINK_TRIG    = 8'h13;
	localparam logic [7:0] FID_FLUSH        = 8'h14;

	// Fixed shapes and reset values
	localparam int NUM_AXES      = 4;
	localparam int QUEUE_DEPTH   = 16;
	localparam int QPTR_W        = 4;
	localparam int MAX_DATA_WORDS = 2;
	localparam logic [15:0] TRIG_EN_MASK  = 16'h000f;
	localparam logic [15:0] LIMIT_EN_MASK = 16'h0fff;
	localparam logic [15:0] EN_RESET      = 16'h0000;
	localparam logic [15:0] BRK_MODE_REL  = 16'hffff;
	localparam int SERVO_IO_OFFSET = 4;

	// One queued result
	typedef struct packed {
		logic [7:0]  axis;
		logic [7:0]  fid;
		logic [31:0] data;
	} ret_entry_t;

	// Per-axis breakpoint state
	typedef struct packed {
		logic        armed;
		logic        relative;
		logic        fired;
		logic [1:0]  link;   // 0 none, else buffer number minus one plus one
		logic [2:0]  link_spare;
		logic [31:0] target;
	} brk_t;

endpackage : motion_cmd_pkg

// ===== test/motion_cmd_trigger_unit_assertions.sv
// Purpose: Port-level checks for the motion command unit
// Assumes: One clock; inputs synchronised within four cycles
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ns
module motion_cmd_trigger_unit_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cmd_valid,
	input wire logic [1:0]  cmd_wcount,
	input wire logic [7:0]  io_in,
	input wire logic [7:0]  io_in_value,
	input wire logic [7:0]  brk_out,
	input wire logic [3:0]  time_brk_arm,
	input wire logic [3:0]  trig_start,
	input wire logic [3:0]  axis_halt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A GO write; packets may only follow one
	wire go_w = psel && penable && pwrite && paddr == motion_cmd_pkg::OFS_CMD_GO;
	sequence hole_rd_s;
		psel && penable && !pwrite && paddr == 8'h24;
	endsequence
	// Pins held long enough to cross the synchroniser
	sequence io_still_s;
		$stable(io_in) [*6];
	endsequence
	a_ready_no_err:
	assert property (psel && penable |-> pready && !pslverr) else $error("apb answer wrong");
	a_hole_reads_zero:
	assert property (hole_rd_s |-> prdata == 32'h0) else $error("unmapped read not zero");
	a_cmd_after_go:
	assert property (cmd_valid |-> $past(go_w) || $past(go_w, 2)) else $error("stray packet");
	a_wcount_max:
	assert property (cmd_valid |-> cmd_wcount <= 2'h2) else $error("packet too long");
	a_halt_one_cycle:
	assert property ((axis_halt & $past(axis_halt)) == 4'h0) else $error("halt not a pulse");
	a_trig_one_cycle:
	assert property ((trig_start & $past(trig_start)) == 4'h0) else $error("start not pulse");
	a_brk_one_map:
	assert property ((brk_out[3:0] & brk_out[7:4]) == 4'h0) else $error("breakpoint on both");
	a_time_arm_go:
	assert property (time_brk_arm != 4'h0 |-> $past(go_w) || $past(go_w, 2))
		else $error("time arm without command");
	a_io_value_sync:
	assert property (io_still_s |-> io_in_value == io_in) else $error("input not readable");
endmodule : motion_cmd_trigger_unit_assertions
bind motion_cmd_trigger_unit motion_cmd_trigger_unit_assertions u_chk (.*);

// ===== test/motion_core_model.sv
// Purpose: Stand-in for the motion core answering function packets
// Assumes: One result per packet after a chosen delay
// Notes:   Result data is the inverted packet data
`timescale 1ns/1ns
module motion_core_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_axis,
	input  wire logic [7:0]  cmd_fid,
	input  wire logic [31:0] cmd_data,
	input  wire logic [2:0]  dly,
	output logic             res_valid,
	output logic [7:0]       res_axis,
	output logic [7:0]       res_fid,
	output logic [31:0]      res_data
);
	logic [31:0] hold;
	int          cnt;
	// Idle data toggles so a stale value is never mistaken for a result
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			res_valid <= 1'b0;
			res_data  <= 32'h0;
			cnt       <= 0;
		end
		else
		begin
			res_valid <= 1'b0;
			res_data  <= ~res_data;
			if (cmd_valid)
			begin
				cnt      <= dly + 1;
				res_axis <= cmd_axis;
				res_fid  <= cmd_fid;
				hold     <= ~cmd_data;
			end
			else if (cnt == 1)
			begin
				res_valid <= 1'b1;
				res_data  <= hold;
				cnt       <= 0;
			end
			else if (cnt > 1)
				cnt <= cnt - 1;
		end
endmodule : motion_core_model

// ===== test/tb_motion_cmd_trigger_unit.sv
// Purpose: Self-checking bench for the motion command unit
// Assumes: Stepper board unless a test selects servo
// Notes:   Core side answers through the model
`timescale 1ns/1ns
module tb_motion_cmd_trigger_unit;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_valid, res_valid;
	logic [7:0]   paddr, cmd_axis, cmd_fid, res_axis, res_fid, io_in, io_dir_in, io_in_value;
	logic [7:0]   brk_out, s;
	logic [31:0]  pwdata, prdata, cmd_data, res_data, rd, d, t;
	logic [1:0]   cmd_wcount;
	logic [127:0] axis_pos;
	logic [3:0]   axis_start, time_brk_arm, trig_start, axis_halt;
	logic [11:0]  limit_in;
	logic [2:0]   dly;
	logic [3:0]   arm_seen = 4'h0;
	logic [31:0]  q[$];
	int           failures = 0, tests_run = 0, seed = 19784, cyc = 0;
	motion_cmd_trigger_unit u_motion_cmd_trigger_unit (.*);
	motion_core_model u_motion_core_model (.*);
	// Clock
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			print_verdict;
		end
	end
	// Time-breakpoint arming seen since reset
	always @(posedge pclk)
		arm_seen <= arm_seen | time_brk_arm;
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// One APB transfer; read data taken at the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		{psel, penable} <= 2'b00;
	endtask : apb
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd & m);
	endtask : rdc
	// Send a packet and wait for the core's answer, or pop the queue
	task go(input logic [7:0] ax, f, input logic [1:0] m, input logic [31:0] dt,
		input logic [1:0] nw);
		int i;
		apb(1'b1, motion_cmd_pkg::OFS_CMD_WORD0, {8'h02 + 8'(nw), 6'h0, m, f, ax});
		apb(1'b1, motion_cmd_pkg::OFS_CMD_DATA, dt);
		apb(1'b1, motion_cmd_pkg::OFS_CMD_GO, 32'h0);
		if (m != motion_cmd_pkg::OP_READ)
		begin
			i = 0;
			while (cmd_valid !== 1'b1 && i < 4)
			begin
				@(posedge pclk);
				i++;
			end
			chk("packet", {1'b1, ax, f, dt, nw},
				{cmd_valid, cmd_axis, cmd_fid, cmd_data, cmd_wcount});
			while (res_valid !== 1'b1)
				@(posedge pclk);
			@(posedge pclk);
		end
	endtask : go
	// Wait for an output; w picks breakpoint, trigger start or halt
	task wev(input string n, input int w, input logic [7:0] e);
		s = 8'h0;
		for (int i = 0; i < 12 && s == 8'h0; i++)
		begin
			@(posedge pclk);
			s = (w == 0) ? brk_out & e : (w == 1) ? {4'h0, trig_start} : {4'h0, axis_halt};
		end
		chk(n, e, s);
	endtask : wev
	task brk(input logic [7:0] ax, input logic [31:0] m);
		go(ax, motion_cmd_pkg::FID_ENABLE_BRK, motion_cmd_pkg::OP_SEND_READ, m, 2'h1);
	endtask : brk
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, dly} = '0;
		{axis_pos, axis_start, io_in, io_dir_in, limit_in} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc("trig_en", motion_cmd_pkg::OFS_TRIG_EN, 32'h0, 32'hffff);
		rdc("lim_en", motion_cmd_pkg::OFS_LIMIT_EN, 32'h0, 32'hffff);
		rdc("hole", 8'h24, 32'h0, 32'hffffffff);
		apb(1'b1, motion_cmd_pkg::OFS_BRK_CFG, 32'h2);
		// Deferred results come back oldest first
		for (int k = 0; k < 3; k++)
		begin
			d = $random(seed);
			dly <= 3'($random(seed));
			q.push_back(d);
			go(8'(k), 8'h20 + 8'(k), motion_cmd_pkg::OP_SEND, d, 2'(k));
		end
		rdc("level", motion_cmd_pkg::OFS_STATUS, 32'h003, 32'h1ff);
		for (int k = 0; k < 3; k++)
		begin
			go(8'h0, 8'h0, motion_cmd_pkg::OP_READ, 32'h0, 2'h0);
			rdc("head", motion_cmd_pkg::OFS_RET_HEAD, {8'h20 + 8'(k), 8'(k)}, 32'hffff);
			rdc("data", motion_cmd_pkg::OFS_RET_DATA, ~q.pop_front(), 32'hffffffff);
		end
		rdc("drained", motion_cmd_pkg::OFS_STATUS, 32'h100, 32'h1ff);
		go(8'h0, 8'h0, motion_cmd_pkg::OP_READ, 32'h0, 2'h0);
		rdc("none", motion_cmd_pkg::OFS_STATUS, 32'h0, 32'h400);
		// Immediate result is delivered and not queued
		d = $random(seed);
		go(8'h2, 8'h21, motion_cmd_pkg::OP_SEND_READ, d, 2'h2);
		rdc("direct", motion_cmd_pkg::OFS_STATUS, 32'h500, 32'h5ff);
		rdc("ddata", motion_cmd_pkg::OFS_RET_DATA, ~d, 32'hffffffff);
		go(8'h1, 8'h22, motion_cmd_pkg::OP_SEND, d, 2'h2);
		go(8'h1, motion_cmd_pkg::FID_FLUSH, motion_cmd_pkg::OP_SEND, 32'h0, 2'h0);
		rdc("flushed", motion_cmd_pkg::OFS_STATUS, 32'h001, 32'h1ff);
		go(8'h0, 8'h0, motion_cmd_pkg::OP_READ, 32'h0, 2'h0);
		rdc("fhead", motion_cmd_pkg::OFS_RET_HEAD,
			{motion_cmd_pkg::FID_FLUSH, 8'h1}, 32'hffff);
		$display("queue tests done");
		// Enable words keep only their defined bits
		go(8'h0, motion_cmd_pkg::FID_ENABLE_TRIG, motion_cmd_pkg::OP_SEND_READ, 32'hffff, 2'h1);
		rdc("trig_en", motion_cmd_pkg::OFS_TRIG_EN, 32'hf, 32'hffffffff);
		go(8'h0, motion_cmd_pkg::FID_ENABLE_LIMIT, motion_cmd_pkg::OP_SEND_READ, 32'hffff, 2'h1);
		rdc("lim_en", motion_cmd_pkg::OFS_LIMIT_EN, 32'hfff, 32'hffffffff);
		io_in <= 8'h04;
		wev("trig", 1, 8'h04);
		repeat (4) @(posedge pclk);
		chk("io_value", 8'h04, io_in_value);
		io_in <= 8'h0;
		for (int a = 0; a < 4; a++)
			for (int j = 0; j < 3; j++)
			begin
				limit_in <= 12'h1 << ((j == 0) ? 7 - 2 * a : (j == 1) ? 6 - 2 * a : 11 - a);
				wev("halt", 2, 8'h1 << a);
				limit_in <= 12'h0;
				repeat (6) @(posedge pclk);
			end
		$display("enable tests done");
		// Absolute hit on a linked axis fires once and starts buffer three
		t = $random(seed) | 32'h1;
		go(8'h1, motion_cmd_pkg::FID_LINK_TRIG, motion_cmd_pkg::OP_SEND_READ, 32'h3, 2'h1);
		apb(1'b1, motion_cmd_pkg::OFS_BRK_POS0 + 8'h4, t);
		brk(8'h1, 32'h0);
		axis_pos[63:32] <= t;
		wev("abs", 0, 8'h02);
		chk("link", 4'h4, trig_start);
		s = 8'h0;
		axis_pos[63:32] <= 32'h0;
		repeat (3) @(posedge pclk);
		axis_pos[63:32] <= t;
		repeat (6)
		begin
			@(posedge pclk);
			s = s | trig_start;
		end
		chk("once", {8'h0, 8'h02}, {s, brk_out & 8'h02});
		axis_pos[63:32] <= 32'h0;
		go(8'h1, motion_cmd_pkg::FID_LINK_TRIG, motion_cmd_pkg::OP_SEND_READ, 32'h0, 2'h1);
		brk(8'h1, 32'h0);
		axis_pos[63:32] <= t;
		wev("rearm", 0, 8'h02);
		chk("unlink", 4'h0, trig_start);
		// Relative hit counts from the position at enable
		d = $random(seed) & 32'hffff;
		axis_pos[95:64] <= t;
		apb(1'b1, motion_cmd_pkg::OFS_BRK_POS0 + 8'h8, d | 32'h1);
		brk(8'h2, 32'(motion_cmd_pkg::BRK_MODE_REL));
		axis_pos[95:64] <= t + (d | 32'h1);
		wev("rel", 0, 8'h04);
		// Open-loop axis stays silent; open-loop board reports an error
		apb(1'b1, motion_cmd_pkg::OFS_BRK_CFG, 32'h82);
		apb(1'b1, motion_cmd_pkg::OFS_BRK_POS0 + 8'hc, t);
		brk(8'h3, 32'h0);
		axis_pos[127:96] <= t;
		repeat (8) @(posedge pclk);
		chk("open", 8'h0, brk_out & 8'h08);
		apb(1'b1, motion_cmd_pkg::OFS_BRK_CFG, 32'h0);
		brk(8'h0, 32'h0);
		rdc("ferr", motion_cmd_pkg::OFS_STATUS, 32'h800, 32'h800);
		// Servo board moves the output up four bits
		apb(1'b1, motion_cmd_pkg::OFS_BRK_CFG, 32'h1);
		apb(1'b1, motion_cmd_pkg::OFS_BRK_POS0, t);
		brk(8'h0, 32'h0);
		chk("tarm", 4'h1, arm_seen);
		axis_pos[31:0] <= t;
		wev("servo", 0, 8'h10);
		$display("breakpoint tests done");
		print_verdict;
	end
endmodule : tb_motion_cmd_trigger_unit
